// ===== verilog/cbh_regs.sv
// host register bank, capture address generator and sample buffer
// assumes host strobes are one-cycle pulses in the clock domain
`default_nettype none

module cbh_regs (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                srst,
  // host byte port
  input  wire cbh_pkg::cbh_io_req_t io_req,
  output logic [7:0]               io_rdata,
  output logic                     io_rvalid,
  // converter sample stream
  input  wire logic                adc_valid,
  input  wire logic [11:0]         adc_code,
  output logic                     adc_ready,
  // trigger pins
  input  wire logic                trig_pin,
  input  wire logic                analog_above,
  // register outputs to front end and timer
  output cbh_pkg::cbh_timer_wr_t   timer_wr,
  output logic [7:0]               chan_ctrl,
  output logic [1:0]               range_span,
  output logic                     range_bipolar,
  output logic [7:0]               trig_level
);

  ////////////////////////////////////////////////////////////////////
  // state
  cbh_pkg::cbh_state_t state;
  logic [7:0]          ctrl;
  logic [19:0]         agen;
  logic [19:0]         trig_addr;
  logic [19:0]         post_left;
  logic [15:0]         cnt1_word;
  logic                cnt1_hi;
  logic                both_hi;
  logic                trig_seen;
  logic                done;
  logic                full;
  logic                wrote_any;
  logic [7:0]          range_reg;
  logic [15:0]         mem [0:(1<<20)-1];

  logic [1:0] trace_sel;
  logic       trace_select_upper;
  logic       trace_select_lower;
  logic       test_mode;
  logic       rd_hit;
  logic       wr_hit;
  logic [3:0] a;
  logic       mem_busy;
  logic       res_read;
  logic       adv_read;
  logic       cap_on;
  logic       take;
  logic       trig_evt;
  logic       start_req;
  logic [15:0] cur_word;

  assign a                  = io_req.addr;
  assign rd_hit             = io_req.rd;
  assign wr_hit             = io_req.wr;
  assign trace_sel          = ctrl[1:0];
  assign trace_select_upper = trace_sel[1];
  assign trace_select_lower = trace_sel[0];
  assign test_mode = trace_select_upper & trace_select_lower;
  assign cur_word  = mem[agen];
  assign res_read  = rd_hit && (a == cbh_pkg::OFF_LOW ||
                     a == cbh_pkg::OFF_HIGH || a == cbh_pkg::OFF_BOTH);
  // high byte read, or second read at offset 2, steps the pointer
  assign adv_read  = rd_hit && (a == cbh_pkg::OFF_HIGH ||
                     (a == cbh_pkg::OFF_BOTH && both_hi));
  assign mem_busy  = (res_read || (wr_hit && test_mode &&
                     (a == cbh_pkg::OFF_LOW || a == cbh_pkg::OFF_HIGH)));
  assign cap_on    = (state == cbh_pkg::CBH_CAPT) ||
                     (state == cbh_pkg::CBH_POST);

  ////////////////////////////////////////////////////////////////////
  // two-entry sample buffer
  logic [11:0] fbuf [0:1];
  logic        f_wp;
  logic        f_rp;
  logic [1:0]  f_cnt;
  logic        f_out_valid;
  logic        f_out_ready;
  logic        f_push;
  logic        f_pop;

  assign adc_ready   = (f_cnt != 2'd2);
  assign f_out_valid = (f_cnt != 2'd0);
  // host memory access takes the port; capture stalls, idle drops
  assign f_out_ready = cap_on ? !mem_busy : 1'b1;
  assign f_push      = adc_valid && adc_ready;
  assign f_pop       = f_out_valid && f_out_ready;
  assign take        = f_pop && cap_on;

  always_ff @(posedge clock) begin
    if (srst) begin
      f_wp  <= 1'b0;
      f_rp  <= 1'b0;
      f_cnt <= 2'd0;
    end else begin
      if (f_push) begin
        fbuf[f_wp] <= adc_code;
        f_wp       <= ~f_wp;
      end
      if (f_pop) begin
        f_rp <= ~f_rp;
      end
      f_cnt <= f_cnt + {1'b0, f_push} - {1'b0, f_pop};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // trigger pin synchronisers and edge select
  logic [1:0] sy1;
  logic [1:0] sy2;
  logic [1:0] sy3;
  logic       src_now;
  logic       src_was;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clock) begin
        if (srst) begin
          sy1[g] <= 1'b0;
          sy2[g] <= 1'b0;
          sy3[g] <= 1'b0;
        end else begin
          sy1[g] <= g ? analog_above : trig_pin;
          sy2[g] <= sy1[g];
          sy3[g] <= sy2[g];
        end
      end
    end
  endgenerate

  assign src_now = ctrl[cbh_pkg::CTL_DIG] ? sy2[0] : sy2[1];
  assign src_was = ctrl[cbh_pkg::CTL_DIG] ? sy3[0] : sy3[1];
  always_comb begin
    trig_evt = 1'b0;
    if ((cap_on || state == cbh_pkg::CBH_WAIT) &&
        state != cbh_pkg::CBH_POST && ctrl[cbh_pkg::CTL_ARM]) begin
      if (ctrl[cbh_pkg::CTL_INT]) begin
        trig_evt = 1'b1;
      end else if (ctrl[cbh_pkg::CTL_POS]) begin
        trig_evt = src_now & !src_was;
      end else begin
        trig_evt = !src_now & src_was;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control and write-only registers
  assign start_req = wr_hit && a == cbh_pkg::OFF_CTRL &&
                     io_req.wdata[cbh_pkg::CTL_RUN] &&
                     io_req.wdata[1:0] != cbh_pkg::TRACE_TEST;

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl      <= cbh_pkg::BYTE_RST;
      chan_ctrl <= cbh_pkg::BYTE_RST;
      range_reg <= cbh_pkg::BYTE_RST;
      trig_level <= cbh_pkg::BYTE_RST;
      cnt1_word <= 16'h0000;
      cnt1_hi   <= 1'b0;
    end else if (wr_hit) begin
      if (a == cbh_pkg::OFF_CTRL) begin
        ctrl <= io_req.wdata;
      end else if (a == cbh_pkg::OFF_CNT1) begin
        cnt1_hi <= ~cnt1_hi;
        if (cnt1_hi) begin
          cnt1_word[15:8] <= io_req.wdata;
        end else begin
          cnt1_word[7:0] <= io_req.wdata;
        end
      end else if (a == cbh_pkg::OFF_CWORD) begin
        cnt1_hi <= 1'b0;
      end else if (a == cbh_pkg::OFF_CHAN) begin
        chan_ctrl <= io_req.wdata;
      end else if (a == cbh_pkg::OFF_RANGE) begin
        range_reg <= io_req.wdata;
      end else if (a == cbh_pkg::OFF_TLEVEL) begin
        trig_level <= io_req.wdata;
      end
    end else if (state == cbh_pkg::CBH_IDLE && done) begin
      ctrl[cbh_pkg::CTL_RUN] <= 1'b0;
    end
  end

  // span and coding straight from the range register
  assign range_span    = range_reg[1:0];
  assign range_bipolar = range_reg[2];

  // timer counter bytes pass on as one-cycle strobes
  always_ff @(posedge clock) begin
    if (srst) begin
      timer_wr <= '0;
    end else begin
      timer_wr.valid <= wr_hit && a >= cbh_pkg::OFF_CNT0 &&
                        a <= cbh_pkg::OFF_CWORD;
      timer_wr.sel   <= a[1:0];
      timer_wr.data  <= io_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // trace sequencer
  always_ff @(posedge clock) begin
    if (srst) begin
      state     <= cbh_pkg::CBH_IDLE;
      post_left <= 20'h00000;
      done      <= 1'b0;
    end else if (start_req) begin
      done  <= 1'b0;
      state <= (io_req.wdata[1:0] == cbh_pkg::TRACE_POST) ?
               cbh_pkg::CBH_WAIT : cbh_pkg::CBH_CAPT;
    end else if (wr_hit && a == cbh_pkg::OFF_CTRL &&
                 !io_req.wdata[cbh_pkg::CTL_RUN] &&
                 state != cbh_pkg::CBH_IDLE) begin
      state <= cbh_pkg::CBH_IDLE;
      done  <= 1'b1;
    end else begin
      case (state)
        cbh_pkg::CBH_IDLE: begin
          state <= cbh_pkg::CBH_IDLE;
        end
        cbh_pkg::CBH_WAIT, cbh_pkg::CBH_CAPT: begin
          if (trig_evt) begin
            post_left <= {cnt1_word, 4'h0};
            if (trace_sel == cbh_pkg::TRACE_PRE ||
                cnt1_word == 16'h0000) begin
              state <= cbh_pkg::CBH_IDLE;
              done  <= 1'b1;
            end else begin
              state <= cbh_pkg::CBH_POST;
            end
          end
        end
        cbh_pkg::CBH_POST: begin
          if (take) begin
            post_left <= post_left - 20'h00001;
            if (post_left == 20'h00001) begin
              state <= cbh_pkg::CBH_IDLE;
              done  <= 1'b1;
            end
          end
        end
        default: begin
          state <= cbh_pkg::CBH_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // address generator, shared by capture and host readout
  always_ff @(posedge clock) begin
    if (srst) begin
      agen      <= cbh_pkg::ADDR_ONES;
      wrote_any <= 1'b0;
      full      <= 1'b0;
    end else if (wr_hit && a == cbh_pkg::OFF_ACLR) begin
      agen      <= cbh_pkg::ADDR_ONES;
      wrote_any <= 1'b0;
      full      <= 1'b0;
    end else if (wr_hit && a == cbh_pkg::OFF_TADR_LO) begin
      agen[7:0] <= io_req.wdata;
    end else if (wr_hit && a == cbh_pkg::OFF_TADR_MI) begin
      agen[15:8] <= io_req.wdata;
    end else if (wr_hit && a == cbh_pkg::OFF_TADR_TP) begin
      agen[19:16] <= io_req.wdata[3:0];
    end else if (take) begin
      // interleaved channels land in consecutive words
      agen      <= agen + 20'h00001;
      wrote_any <= 1'b1;
      if (agen == cbh_pkg::ADDR_ONES && wrote_any) begin
        full <= 1'b1;
      end
    end else if (adv_read || (wr_hit && test_mode &&
                 a == cbh_pkg::OFF_HIGH)) begin
      agen <= agen + 20'h00001;
    end
  end

  // sample buffer memory
  always_ff @(posedge clock) begin
    if (take) begin
      mem[agen + 20'h00001] <= {f_out_valid ? fbuf[f_rp] : 12'h000,
                                4'h0};
    end else if (wr_hit && test_mode && a == cbh_pkg::OFF_LOW) begin
      mem[agen] <= {cur_word[15:8], io_req.wdata};
    end else if (wr_hit && test_mode && a == cbh_pkg::OFF_HIGH) begin
      mem[agen] <= {io_req.wdata, cur_word[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // trigger address capture and status bit 2
  always_ff @(posedge clock) begin
    if (srst) begin
      trig_addr <= 20'h00000;
      trig_seen <= 1'b0;
      both_hi   <= 1'b0;
    end else begin
      if (trig_evt) begin
        trig_addr <= agen + 20'h00001;
        trig_seen <= 1'b1;
      end else if (res_read) begin
        trig_seen <= 1'b0;
      end
      if (rd_hit && a == cbh_pkg::OFF_BOTH) begin
        both_hi <= ~both_hi;
      end else if (rd_hit && a == cbh_pkg::OFF_LOW) begin
        both_hi <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // host read data
  logic [19:0] shown_addr;
  logic [7:0]  next_rdata;

  assign shown_addr = trig_seen ? trig_addr : agen;

  always_comb begin
    next_rdata = cbh_pkg::BYTE_RST;
    if (a == cbh_pkg::OFF_LOW) begin
      // memory test shows the whole byte, results only the upper nibble
      next_rdata = test_mode ? cur_word[7:0] :
                   {cur_word[7:4], 4'h0};
    end else if (a == cbh_pkg::OFF_HIGH) begin
      next_rdata = cur_word[15:8];
    end else if (a == cbh_pkg::OFF_BOTH) begin
      next_rdata = both_hi ? cur_word[15:8] : cur_word[7:0];
    end else if (a == cbh_pkg::OFF_CTRL) begin
      next_rdata = ctrl;
    end else if (a == cbh_pkg::OFF_TADR_LO) begin
      next_rdata = shown_addr[7:0];
    end else if (a == cbh_pkg::OFF_TADR_MI) begin
      next_rdata = shown_addr[15:8];
    end else if (a == cbh_pkg::OFF_TADR_TP) begin
      next_rdata = {4'h0, shown_addr[19:16]};
    end else if (a == cbh_pkg::OFF_STATUS) begin
      next_rdata = {4'h0, cap_on || state == cbh_pkg::CBH_WAIT,
                    trig_seen, full, done};
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      io_rdata  <= cbh_pkg::BYTE_RST;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= rd_hit;
      if (rd_hit) begin
        io_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  sequence s_test_wr0;
    wr_hit && !rd_hit && test_mode && a == cbh_pkg::OFF_LOW && !take;
  endsequence
  sequence s_rd0;
    rd_hit && !wr_hit && a == cbh_pkg::OFF_LOW;
  endsequence

  property p_aclr;
    @(posedge clock) disable iff (srst)
    wr_hit && a == cbh_pkg::OFF_ACLR |=> agen == cbh_pkg::ADDR_ONES;
  endproperty
  a_aclr: assert property (p_aclr)
    else $error("address generator not cleared");

  property p_low_nibble;
    @(posedge clock) disable iff (srst)
    rd_hit && !test_mode && a == cbh_pkg::OFF_LOW
      |=> io_rvalid && io_rdata[3:0] == 4'h0;
  endproperty
  a_low_nibble: assert property (p_low_nibble)
    else $error("low result byte lower nibble not zero");

  property p_high_adv;
    @(posedge clock) disable iff (srst)
    rd_hit && !wr_hit && a == cbh_pkg::OFF_HIGH
      |=> agen == $past(agen) + 20'h00001;
  endproperty
  a_high_adv: assert property (p_high_adv)
    else $error("high byte read did not advance address");

  property p_trig_flag;
    @(posedge clock) disable iff (srst)
    trig_evt |=> trig_seen && trig_addr == $past(agen) + 20'h00001;
  endproperty
  a_trig_flag: assert property (p_trig_flag)
    else $error("trigger not recorded");

  property p_tadr_read;
    @(posedge clock) disable iff (srst)
    rd_hit && a == cbh_pkg::OFF_TADR_LO && trig_seen && !trig_evt
      |=> io_rdata == $past(trig_addr[7:0]);
  endproperty
  a_tadr_read: assert property (p_tadr_read)
    else $error("trigger address low byte wrong");

  property p_wo_zero;
    @(posedge clock) disable iff (srst)
    rd_hit && (a == cbh_pkg::OFF_ACLR || a == cbh_pkg::OFF_CHAN ||
               a == cbh_pkg::OFF_CNT0) |=> io_rdata == 8'h00;
  endproperty
  a_wo_zero: assert property (p_wo_zero)
    else $error("write-only location read non-zero");

  property p_test_loop;
    @(posedge clock) disable iff (srst)
    s_test_wr0 ##1 (!wr_hit && !rd_hit) ##1 s_rd0
      |=> io_rdata == $past(io_req.wdata, 3);
  endproperty
  a_test_loop: assert property (p_test_loop)
    else $error("memory test byte not read back");

  property p_pre_stop;
    @(posedge clock) disable iff (srst)
    state == cbh_pkg::CBH_CAPT && trace_sel == cbh_pkg::TRACE_PRE &&
      trig_evt && !wr_hit |=> state == cbh_pkg::CBH_IDLE ##1 done;
  endproperty
  a_pre_stop: assert property (p_pre_stop)
    else $error("pre-trigger trace did not stop on trigger");

  property p_full_wrap;
    @(posedge clock) disable iff (srst)
    take && !wr_hit && agen == cbh_pkg::ADDR_ONES && wrote_any
      |=> full && agen == 20'h00000;
  endproperty
  a_full_wrap: assert property (p_full_wrap)
    else $error("wrap did not flag buffer full");

  property p_post_end;
    @(posedge clock) disable iff (srst)
    state == cbh_pkg::CBH_POST && take && !wr_hit &&
      post_left == 20'h00001 |=> state == cbh_pkg::CBH_IDLE && done;
  endproperty
  a_post_end: assert property (p_post_end)
    else $error("centred trace did not end after count");

endmodule : cbh_regs

`default_nettype wire

// ===== verilog/cbh_pkg.sv
// constants and types for the capture buffer host register bank
// assumes one 250 MHz clock and a byte-wide host port of 16 locations
// Function
// - sixteen byte registers at base+0..15, some split read and write.
// - offset 0 read: low four result bits in upper nibble, zeros below.
// - writing 3 to offset 3 enters memory test; offset 0 is memory byte.
// - writes to 0 and 1 load test bytes; offset 2 reads both bytes.
// - offsets 4..6 counter data, 7 timer control word, all write-only.
// - any write to offset 8 resets the buffer address generator.
// - offsets 9..11 read trigger address while status bit 2 is set, else the generator; write generator offset bytes.
// - offsets 12..14 write-only channel, range and trigger level registers.
// - channels interleave in buffer; one channel starts at address 0..3.
// - unfilled pre or centred trace keeps oldest sample at address zero.
// - filled pre-trigger trace: oldest sample at trigger address.
// - filled centred trace: oldest sample at trigger address plus count.
// - 12-bit codes: offset binary when bipolar, straight when unipolar.
// - range spans 5, 10 or 20 volts, each unipolar or bipolar.
// - each high result byte read advances the buffer address by one.
// - two-bit trace select: pre, centred, post trigger, memory test.
// - status bit 2 sets on trigger, clears on result read.
`default_nettype none

package cbh_pkg;

  localparam int          ADDR_W      = 20;
  localparam logic [19:0] ADDR_ONES   = 20'hFFFFF;
  localparam logic [3:0]  OFF_LOW     = 4'h0;
  localparam logic [3:0]  OFF_HIGH    = 4'h1;
  localparam logic [3:0]  OFF_BOTH    = 4'h2;
  localparam logic [3:0]  OFF_CTRL    = 4'h3;
  localparam logic [3:0]  OFF_CNT0    = 4'h4;
  localparam logic [3:0]  OFF_CNT1    = 4'h5;
  localparam logic [3:0]  OFF_CNT2    = 4'h6;
  localparam logic [3:0]  OFF_CWORD   = 4'h7;
  localparam logic [3:0]  OFF_ACLR    = 4'h8;
  localparam logic [3:0]  OFF_TADR_LO = 4'h9;
  localparam logic [3:0]  OFF_TADR_MI = 4'hA;
  localparam logic [3:0]  OFF_TADR_TP = 4'hB;
  localparam logic [3:0]  OFF_CHAN    = 4'hC;
  localparam logic [3:0]  OFF_RANGE   = 4'hD;
  localparam logic [3:0]  OFF_TLEVEL  = 4'hE;
  localparam logic [3:0]  OFF_STATUS  = 4'hF;
  // trace select codes
  localparam logic [1:0]  TRACE_PRE   = 2'h0;
  localparam logic [1:0]  TRACE_MID   = 2'h1;
  localparam logic [1:0]  TRACE_POST  = 2'h2;
  localparam logic [1:0]  TRACE_TEST  = 2'h3;
  // control bit positions
  localparam int          CTL_INT     = 2;
  localparam int          CTL_DIG     = 3;
  localparam int          CTL_POS     = 4;
  localparam int          CTL_ARM     = 5;
  localparam int          CTL_RUN     = 6;
  // status bit positions
  localparam int          ST_DONE     = 0;
  localparam int          ST_FULL     = 1;
  localparam int          ST_TRIG     = 2;
  localparam int          ST_BUSY     = 3;
  // range field: span code in [1:0], bipolar in bit 2
  localparam logic [1:0]  SPAN_5V     = 2'h0;
  localparam logic [1:0]  SPAN_10V    = 2'h1;
  localparam logic [1:0]  SPAN_20V    = 2'h2;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam int          POST_SHIFT  = 4;

  typedef enum logic [1:0] {
    CBH_IDLE = 2'b00,
    CBH_WAIT = 2'b01,
    CBH_CAPT = 2'b10,
    CBH_POST = 2'b11
  } cbh_state_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } cbh_io_req_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] sel;
    logic [7:0] data;
  } cbh_timer_wr_t;

endpackage : cbh_pkg

`default_nettype wire

// ===== verification/cbh_host.sv
// host processor model driving the byte register port
// assumes strobes launched at the falling edge, one cycle each except burst, which holds rd for n cycles
`default_nettype none

module cbh_host (
  // clock
  input  wire logic                clock,
  // byte port
  output var cbh_pkg::cbh_io_req_t io_req,
  input  wire logic [7:0]          io_rdata,
  input  wire logic                io_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial io_req = '0;

  //////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    io_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clock);
    io_req <= '0;
  endtask : wr

  // unknown returned when no answer came
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clock);
    io_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clock);
    io_req <= '0;
    d = io_rvalid ? io_rdata : 8'hXX;
  endtask : rd

  // rd held for n back-to-back reads
  task automatic burst(input logic [3:0] a, input int n);
    @(negedge clock);
    io_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    repeat (n) @(negedge clock);
    io_req <= '0;
  endtask : burst

  task automatic rword(output logic [15:0] w);
    rd(4'h0, w[7:0]);
    rd(4'h1, w[15:8]);
  endtask : rword

  task automatic set_ptr(input logic [19:0] p);
    wr(4'h9, p[7:0]);
    wr(4'hA, p[15:8]);
    wr(4'hB, {4'h0, p[19:16]});
  endtask : set_ptr
endmodule : cbh_host

`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the host register bank
// assumes cbh_pkg, cbh_regs and cbh_host are compiled first
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clock, srst, adc_valid, trig_pin, analog_above;
  logic [11:0]            adc_code;
  cbh_pkg::cbh_io_req_t   io_req;
  cbh_pkg::cbh_timer_wr_t timer_wr;
  logic [7:0]             io_rdata, chan_ctrl, trig_level, rb;
  logic                   io_rvalid, adc_ready, range_bipolar, seen;
  logic [1:0]             range_span;
  logic [31:0]            seed, r;
  logic [15:0]            w;
  logic [15:0]            words[4];
  logic [11:0]            codes[5];
  logic [3:0]             wo[8] = '{4'h4, 4'h5, 4'h6, 4'h7,
                                    4'h8, 4'hC, 4'hD, 4'hE};
  int                     err_total, num_checks, cycles;

  cbh_regs u_cbh_regs (.clock(clock), .srst(srst), .io_req(io_req),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .adc_valid(adc_valid),
    .adc_code(adc_code), .adc_ready(adc_ready), .trig_pin(trig_pin),
    .analog_above(analog_above), .timer_wr(timer_wr),
    .chan_ctrl(chan_ctrl), .range_span(range_span),
    .range_bipolar(range_bipolar), .trig_level(trig_level));
  cbh_host u_cbh_host (.clock(clock), .io_req(io_req),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid));

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // valid left high so back-to-back words need no gap
  task automatic send(input logic [11:0] c);
    adc_valid = 1'b1;
    adc_code = c;
    for (int n = 0; n < 50 && adc_ready !== 1'b1; n++) @(negedge clock);
    @(negedge clock);
  endtask : send

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    adc_valid = 1'b0;
    adc_code = 12'h000;
    trig_pin = 1'b0;
    analog_above = 1'b0;
    seed = 32'hE829;
    repeat (4) @(negedge clock);
    srst = 1'b0;
    u_cbh_host.rd(4'hF, rb);
    chk("status", 16'h0000, rb);
    u_cbh_host.rd(4'hB, rb);
    chk("addr top", 16'h000F, rb);
    foreach (wo[i]) begin
      u_cbh_host.rd(wo[i], rb);
      chk("write-only", 16'h0000, rb);
    end
    u_cbh_host.wr(4'hF, 8'hFF);
    u_cbh_host.rd(4'hF, rb);
    chk("status write", 16'h0000, rb);
    $display("test refusals done");
    for (int a = 4; a < 8; a++) begin
      r = rnd();
      u_cbh_host.wr(4'(a), r[7:0]);
      chk("timer", {5'h01, 2'(a), r[7:0]}, timer_wr);
    end
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      u_cbh_host.wr(4'hC, r[7:0]);
      u_cbh_host.wr(4'hD, {5'h00, 1'(k / 3), 2'(k % 3)});
      u_cbh_host.wr(4'hE, r[15:8]);
      chk("chan", r[7:0], chan_ctrl);
      chk("range", {1'(k / 3), 2'(k % 3)},
          {range_bipolar, range_span});
      chk("level", r[15:8], trig_level);
    end
    $display("test control done");
    u_cbh_host.wr(4'h3, 8'h03);
    u_cbh_host.rd(4'h3, rb);
    chk("ctrl", 16'h0003, rb);
    u_cbh_host.set_ptr(20'h00000);
    foreach (words[i]) begin
      r = rnd();
      words[i] = r[15:0];
      u_cbh_host.wr(4'h0, r[7:0]);
      u_cbh_host.wr(4'h1, r[15:8]);
    end
    u_cbh_host.set_ptr(20'h00000);
    foreach (words[i]) begin
      if (i < 2)
        u_cbh_host.rword(w);
      else begin
        u_cbh_host.rd(4'h2, w[7:0]);
        u_cbh_host.rd(4'h2, w[15:8]);
      end
      chk("test word", words[i], w);
    end
    u_cbh_host.rd(4'h9, rb);
    chk("pointer", 16'h0004, rb);
    r = rnd();
    u_cbh_host.wr(4'h0, r[7:0]);
    u_cbh_host.rd(4'h0, rb);
    chk("test byte", r[7:0], rb);
    $display("test memory done");
    u_cbh_host.wr(4'h3, 8'h00);
    u_cbh_host.wr(4'h8, 8'h00);
    u_cbh_host.wr(4'h3, 8'h78);
    foreach (codes[i]) begin
      r = rnd();
      codes[i] = r[11:0];
      send(r[11:0]);
    end
    adc_valid = 1'b0;
    repeat (4) @(negedge clock);
    trig_pin = 1'b1;
    repeat (8) @(negedge clock);
    u_cbh_host.rd(4'hF, rb);
    chk("trig full", 16'h0002, rb[2:1]);
    u_cbh_host.rd(4'h9, rb);
    chk("trig addr", 16'h0005, rb);
    u_cbh_host.set_ptr(20'h00000);
    foreach (codes[i]) begin
      u_cbh_host.rword(w);
      chk("sample", {codes[i], 4'h0}, w);
    end
    u_cbh_host.rd(4'hF, rb);
    chk("trig clear", 16'h0000, rb[2]);
    $display("test capture done");
    for (int m = 1; m < 3; m++) begin
      u_cbh_host.wr(4'h8, 8'h00);
      u_cbh_host.wr(4'h5, 8'h01);
      u_cbh_host.wr(4'h5, 8'h00);
      u_cbh_host.wr(4'h3, 8'h64 | 8'(m));
      repeat (16) begin
        r = rnd();
        send(r[11:0]);
      end
      adc_valid = 1'b0;
      u_cbh_host.rd(4'hF, rb);
      chk("post status", 16'h0005, rb);
      u_cbh_host.rd(4'h9, rb);
      chk("post trig addr", 16'h0000, rb);
    end
    $display("test post trigger done");
    u_cbh_host.wr(4'h8, 8'h00);
    u_cbh_host.wr(4'h3, 8'h40);
    seen = 1'b0;
    adc_valid = 1'b1;
    fork
      u_cbh_host.burst(4'h2, 8);
      repeat (10) begin
        @(negedge clock);
        if (adc_ready === 1'b0)
          seen = 1'b1;
      end
    join
    chk("refused", 16'h0001, seen);
    adc_valid = 1'b0;
    repeat (6) @(negedge clock);
    chk("drained", 16'h0001, adc_ready);
    u_cbh_host.set_ptr(20'hFFFFE);
    send(12'h5A5);
    send(12'hA5A);
    adc_valid = 1'b0;
    u_cbh_host.wr(4'h3, 8'h00);
    u_cbh_host.rd(4'hF, rb);
    chk("done full", 16'h0003, rb[1:0]);
    $display("test stall done");
    finish_test();
  end
endmodule : tb

`default_nettype wire
